// ==== ftao_pkg.sv ====
// package: constants and carrier types for the fault type alarm outputs block
package ftao_pkg;

  // --------------------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int TICK_US = 10000;
  localparam int TICK_CYC = (CLK_HZ / 1000000) * TICK_US;
  localparam int POLL_MS = 500;
  localparam int POLL_TICKS = (POLL_MS * 1000) / TICK_US;
  localparam int RESET_MIN_MS = 50;
  localparam int RESET_TICKS = (RESET_MIN_MS * 1000 + TICK_US - 1) / TICK_US;
  localparam logic [8:0] ALARM_TIME_MIN = 9'h001;
  localparam logic [8:0] ALARM_TIME_MAX = 9'h1F4;
  localparam int RUN_MULT_X10 = 25;

  // --------------------------------------------------------------------------
  // serial defaults
  // --------------------------------------------------------------------------
  localparam int BAUD_DEFAULT = 19200;
  localparam logic [7:0] STATION_DEFAULT = 8'h0A;
  localparam logic [15:0] REMOTE_ENABLE_LOC = 16'h0005;

  // --------------------------------------------------------------------------
  // widths and reset values
  // --------------------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [8:0] TIME_RESET = 9'h000;
  localparam logic [19:0] DIV_RESET = 20'h00000;
  localparam int ALARM_N = 4;
  localparam int AL_TOTAL = 0;
  localparam int AL_BARE = 1;
  localparam int AL_PIN = 2;
  localparam int AL_GROSS = 3;

  typedef enum logic [1:0] {
    FTAO_PULSE = 2'b00,
    FTAO_HELD = 2'b01,
    FTAO_HELD_HV = 2'b10
  } ftao_mode_t;

  typedef enum logic [1:0] {
    FTAO_IDLE = 2'b00,
    FTAO_ARC = 2'b01,
    FTAO_CONTACT = 2'b10
  } ftao_state_t;

  typedef struct packed {
    logic pinhole;
    logic contact;
    logic multi_pinhole;
    logic gross_barewire;
  } ftao_faults_t;

  typedef struct packed {
    logic [15:0] total;
    logic [15:0] pinhole;
    logic [15:0] contact;
    logic [15:0] multi_pinhole;
    logic [15:0] gross_barewire;
  } ftao_counts_t;

endpackage : ftao_pkg

// ==== ftao_alarm_outputs.sv ====
// module: fault typing, type alarms, count limits and serial keep-alive
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------------
// Overview of operation
// - gross barewire alarm pulses for its hold time in pulse mode.
// - each alarm hold time is 0.01 to 5.0 s, used in pulse mode only.
// - in held mode an alarm stays on until a panel or remote reset.
// - total fault limit output on when total count reaches its threshold.
// - pinhole limit output on when pinhole count reaches its threshold.
// - contact limit output on when contact count reaches its threshold.
// - multi pinhole limit on when multi pinhole count reaches threshold.
// - gross barewire limit on when its count reaches its threshold.
// - combination select 0 uses pinhole or multi pinhole limits.
// - combination select 1 uses contact or gross barewire limits.
// - any barewire alarm fires on contact or gross barewire faults only.
// - any pinhole alarm fires on pinhole or multi pinhole faults only.
// - a single discharge without contact is a pinhole fault.
// - a discharge with contact is a contact fault, any length.
// - non-contact discharges spanning 2.5 electrode lengths are multi pinhole.
// - contact lasting 2.5 electrode lengths is a gross barewire fault.
// - the 2.5 length bound is turned into time from the line speed.
// - in serial mode remote enable must be polled every 500 ms or high voltage drops.
// - serial defaults 19200 baud 8N1, no flow control, station 10.
// - serial link carries Modbus RTU frames over full-duplex RS-485.
// - total fault alarm has a third mode that also cuts high voltage.
module ftao_alarm_outputs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic discharge_pin,
  input wire logic contact_pin,
  input wire logic fault_reset_pin,
  input wire logic panel_reset,
  input wire logic count_reset,
  input wire logic [15:0] run_cycles_per_tick,
  input wire logic serial_mode,
  input wire logic remote_enable_poll,
  input wire logic [1:0] total_fault_alarm_mode,
  input wire logic [8:0] total_fault_alarm_time,
  input wire logic any_barewire_alarm_mode,
  input wire logic [8:0] any_barewire_alarm_time,
  input wire logic any_pinhole_alarm_mode,
  input wire logic [8:0] any_pinhole_alarm_time,
  input wire logic gross_barewire_alarm_mode,
  input wire logic [8:0] gross_barewire_alarm_time,
  input wire logic [15:0] total_fault_threshold,
  input wire logic [15:0] pinhole_threshold,
  input wire logic [15:0] contact_threshold,
  input wire logic [15:0] multi_pinhole_threshold,
  input wire logic [15:0] gross_barewire_threshold,
  input wire logic combination_select,
  output logic total_fault_alarm,
  output logic any_barewire_alarm,
  output logic any_pinhole_alarm,
  output logic gross_barewire_alarm,
  output logic total_fault_limit_out,
  output logic pinhole_limit_out,
  output logic contact_limit_out,
  output logic multi_pinhole_limit_out,
  output logic gross_barewire_limit_out,
  output logic combination_limit_out,
  output logic hv_enable,
  output ftao_pkg::ftao_faults_t fault_event
);

  typedef struct packed {
    logic [1:0] dis_s;
    logic [1:0] con_s;
    logic [1:0] frs_s;
    logic [19:0] div;
    logic tick;
    ftao_pkg::ftao_state_t st;
    logic [15:0] run;
    logic run_long;
    logic [3:0] fr_cnt;
    logic [9:0] poll_cnt;
    logic hv_trip;
    logic hv;
    logic [3:0] al;
    logic [3:0][8:0] hold;
    ftao_pkg::ftao_counts_t cnt;
    logic [5:0] lim;
    ftao_pkg::ftao_faults_t ev;
  } ftao_state_r_t;

  ftao_state_r_t s_r;
  ftao_state_r_t s_nxt;

  // threshold compare shared by all limit outputs
  function automatic logic ftao_reached(input logic [15:0] c, input logic [15:0] t);
    return c >= t;
  endfunction : ftao_reached

  logic [3:0] trig;
  logic [3:0] held;
  logic [3:0][8:0] atime;
  logic clear_all;
  logic run_thresh;

  always_comb begin
    atime[ftao_pkg::AL_TOTAL] = total_fault_alarm_time;
    atime[ftao_pkg::AL_BARE] = any_barewire_alarm_time;
    atime[ftao_pkg::AL_PIN] = any_pinhole_alarm_time;
    atime[ftao_pkg::AL_GROSS] = gross_barewire_alarm_time;
    held[ftao_pkg::AL_TOTAL] = total_fault_alarm_mode != ftao_pkg::FTAO_PULSE;
    held[ftao_pkg::AL_BARE] = any_barewire_alarm_mode;
    held[ftao_pkg::AL_PIN] = any_pinhole_alarm_mode;
    held[ftao_pkg::AL_GROSS] = gross_barewire_alarm_mode;
  end

  always_comb begin
    s_nxt = s_r;
    // --------------------------------------------------------------------
    // input synchronisers and 10 ms time base
    // --------------------------------------------------------------------
    s_nxt.dis_s = {s_r.dis_s[0], discharge_pin};
    s_nxt.con_s = {s_r.con_s[0], contact_pin};
    s_nxt.frs_s = {s_r.frs_s[0], fault_reset_pin};
    s_nxt.tick = 1'b0;
    if (s_r.div == 20'(ftao_pkg::TICK_CYC - 1)) begin
      s_nxt.div = ftao_pkg::DIV_RESET;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 20'h00001;
    end
    // remote reset: closure qualified for more than 50 ms
    clear_all = panel_reset;
    if (!s_r.frs_s[1]) begin
      s_nxt.fr_cnt = 4'h0;
    end else if (s_r.tick && s_r.fr_cnt != 4'(ftao_pkg::RESET_TICKS + 1)) begin
      s_nxt.fr_cnt = s_r.fr_cnt + 4'h1;
    end
    // fire only on the qualifying tick; a release at the last count must not clear
    if (s_r.frs_s[1] && s_r.tick
        && s_r.fr_cnt == 4'(ftao_pkg::RESET_TICKS)) begin
      clear_all = 1'b1;
    end
    // --------------------------------------------------------------------
    // fault typing; run length scaled from line speed input
    // --------------------------------------------------------------------
    s_nxt.ev = '0;
    run_thresh = s_r.run >= run_cycles_per_tick;
    unique case (s_r.st)
      ftao_pkg::FTAO_IDLE: begin
        s_nxt.run = ftao_pkg::CNT_RESET;
        s_nxt.run_long = 1'b0;
        if (s_r.con_s[1]) begin
          s_nxt.st = ftao_pkg::FTAO_CONTACT;
          s_nxt.ev.contact = 1'b1;
        end else if (s_r.dis_s[1]) begin
          s_nxt.st = ftao_pkg::FTAO_ARC;
          s_nxt.ev.pinhole = 1'b1;
        end
      end
      ftao_pkg::FTAO_ARC: begin
        if (!run_thresh) begin
          s_nxt.run = s_r.run + 16'h0001;
        end
        if (run_thresh && !s_r.run_long) begin
          s_nxt.run_long = 1'b1;
          s_nxt.ev.multi_pinhole = 1'b1;
        end
        if (s_r.con_s[1]) begin
          s_nxt.st = ftao_pkg::FTAO_CONTACT;
          s_nxt.run = ftao_pkg::CNT_RESET;
          s_nxt.run_long = 1'b0;
          s_nxt.ev.contact = 1'b1;
        end else if (!s_r.dis_s[1]) begin
          s_nxt.st = ftao_pkg::FTAO_IDLE;
        end
      end
      ftao_pkg::FTAO_CONTACT: begin
        if (!run_thresh) begin
          s_nxt.run = s_r.run + 16'h0001;
        end
        if (run_thresh && !s_r.run_long) begin
          s_nxt.run_long = 1'b1;
          s_nxt.ev.gross_barewire = 1'b1;
        end
        if (!s_r.con_s[1]) begin
          s_nxt.st = ftao_pkg::FTAO_IDLE;
        end
      end
      default: begin
        s_nxt.st = ftao_pkg::FTAO_IDLE;
      end
    endcase
    // --------------------------------------------------------------------
    // counters
    // --------------------------------------------------------------------
    if (count_reset) begin
      s_nxt.cnt = '0;
    end else begin
      if (|s_r.ev && s_r.cnt.total != 16'hFFFF) begin
        s_nxt.cnt.total = s_r.cnt.total + 16'h0001;
      end
      if (s_r.ev.pinhole && s_r.cnt.pinhole != 16'hFFFF) begin
        s_nxt.cnt.pinhole = s_r.cnt.pinhole + 16'h0001;
      end
      if (s_r.ev.contact && s_r.cnt.contact != 16'hFFFF) begin
        s_nxt.cnt.contact = s_r.cnt.contact + 16'h0001;
      end
      if (s_r.ev.multi_pinhole && s_r.cnt.multi_pinhole != 16'hFFFF) begin
        s_nxt.cnt.multi_pinhole = s_r.cnt.multi_pinhole + 16'h0001;
      end
      if (s_r.ev.gross_barewire && s_r.cnt.gross_barewire != 16'hFFFF) begin
        s_nxt.cnt.gross_barewire = s_r.cnt.gross_barewire + 16'h0001;
      end
    end
    s_nxt.lim[0] = ftao_reached(s_r.cnt.total, total_fault_threshold);
    s_nxt.lim[1] = ftao_reached(s_r.cnt.pinhole, pinhole_threshold);
    s_nxt.lim[2] = ftao_reached(s_r.cnt.contact, contact_threshold);
    s_nxt.lim[3] = ftao_reached(s_r.cnt.multi_pinhole, multi_pinhole_threshold);
    s_nxt.lim[4] = ftao_reached(s_r.cnt.gross_barewire, gross_barewire_threshold);
    s_nxt.lim[5] = combination_select ? (s_nxt.lim[2] | s_nxt.lim[4])
                                      : (s_nxt.lim[1] | s_nxt.lim[3]);
    // --------------------------------------------------------------------
    // type alarms: pulse or held; a new fault wins over a reset
    // --------------------------------------------------------------------
    trig[ftao_pkg::AL_TOTAL] = |s_r.ev;
    trig[ftao_pkg::AL_BARE] = s_r.ev.contact | s_r.ev.gross_barewire;
    trig[ftao_pkg::AL_PIN] = s_r.ev.pinhole | s_r.ev.multi_pinhole;
    trig[ftao_pkg::AL_GROSS] = s_r.ev.gross_barewire;
    for (int i = 0; i < ftao_pkg::ALARM_N; i++) begin
      if (trig[i]) begin
        s_nxt.al[i] = 1'b1;
        // clamp to the documented 0.01..5.0 s range
        if (atime[i] < ftao_pkg::ALARM_TIME_MIN) begin
          s_nxt.hold[i] = ftao_pkg::ALARM_TIME_MIN;
        end else if (atime[i] > ftao_pkg::ALARM_TIME_MAX) begin
          s_nxt.hold[i] = ftao_pkg::ALARM_TIME_MAX;
        end else begin
          s_nxt.hold[i] = atime[i];
        end
      end else if (held[i]) begin
        if (clear_all) begin
          s_nxt.al[i] = 1'b0;
        end
      end else if (s_r.al[i] && s_r.tick) begin
        if (s_r.hold[i] <= 9'h001) begin
          s_nxt.al[i] = 1'b0;
          s_nxt.hold[i] = ftao_pkg::TIME_RESET;
        end else begin
          s_nxt.hold[i] = s_r.hold[i] - 9'h001;
        end
      end
    end
    // --------------------------------------------------------------------
    // high voltage gating: serial keep-alive and trip mode
    // --------------------------------------------------------------------
    // polls come decoded from the serial front end
    if (remote_enable_poll || !serial_mode) begin
      s_nxt.poll_cnt = 10'h000;
    end else if (s_r.tick && s_r.poll_cnt != 10'(ftao_pkg::POLL_TICKS)) begin
      s_nxt.poll_cnt = s_r.poll_cnt + 10'h001;
    end
    if (trig[ftao_pkg::AL_TOTAL] && total_fault_alarm_mode == ftao_pkg::FTAO_HELD_HV) begin
      s_nxt.hv_trip = 1'b1;
    end else if (clear_all) begin
      s_nxt.hv_trip = 1'b0;
    end
    s_nxt.hv = !s_nxt.hv_trip && s_nxt.poll_cnt != 10'(ftao_pkg::POLL_TICKS);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs, each straight from state
  // --------------------------------------------------------------------------
  assign total_fault_alarm = s_r.al[ftao_pkg::AL_TOTAL];
  assign any_barewire_alarm = s_r.al[ftao_pkg::AL_BARE];
  assign any_pinhole_alarm = s_r.al[ftao_pkg::AL_PIN];
  assign gross_barewire_alarm = s_r.al[ftao_pkg::AL_GROSS];
  assign total_fault_limit_out = s_r.lim[0];
  assign pinhole_limit_out = s_r.lim[1];
  assign contact_limit_out = s_r.lim[2];
  assign multi_pinhole_limit_out = s_r.lim[3];
  assign gross_barewire_limit_out = s_r.lim[4];
  assign combination_limit_out = s_r.lim[5];
  assign fault_event = s_r.ev;
  assign hv_enable = s_r.hv;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_gross_hit;
    fault_event.gross_barewire;
  endsequence

  property p_gross_on;
    s_gross_hit |=> gross_barewire_alarm;
  endproperty
  a_gross_on: assert property (p_gross_on) else $error("gross alarm missed fault");

  property p_held_stays;
    gross_barewire_alarm && gross_barewire_alarm_mode && !panel_reset && !s_r.frs_s[1]
      |=> gross_barewire_alarm;
  endproperty
  a_held_stays: assert property (p_held_stays) else $error("held alarm dropped");

  property p_total_lim;
    ##1 total_fault_limit_out == ($past(s_r.cnt.total) >= $past(total_fault_threshold));
  endproperty
  a_total_lim: assert property (p_total_lim) else $error("total limit wrong");

  property p_pin_lim;
    ##1 pinhole_limit_out == ($past(s_r.cnt.pinhole) >= $past(pinhole_threshold));
  endproperty
  a_pin_lim: assert property (p_pin_lim) else $error("pinhole limit wrong");

  property p_comb;
    ##1 combination_limit_out == ($past(combination_select)
      ? (contact_limit_out | gross_barewire_limit_out)
      : (pinhole_limit_out | multi_pinhole_limit_out));
  endproperty
  a_comb: assert property (p_comb) else $error("combination limit wrong");

  property p_bare_only;
    fault_event.pinhole && !fault_event.contact && !fault_event.gross_barewire
      && !any_barewire_alarm |=> !any_barewire_alarm;
  endproperty
  a_bare_only: assert property (p_bare_only) else $error("barewire alarm on pinhole");

  property p_pin_alarm;
    fault_event.multi_pinhole |=> any_pinhole_alarm;
  endproperty
  a_pin_alarm: assert property (p_pin_alarm) else $error("pinhole alarm missed");

  property p_count_clr;
    count_reset |=> ##1 !pinhole_limit_out || $past(pinhole_threshold) == 16'h0000;
  endproperty
  a_count_clr: assert property (p_count_clr) else $error("limit after count reset");

  property p_trip;
    fault_event != '0 && total_fault_alarm_mode == ftao_pkg::FTAO_HELD_HV |=> !hv_enable;
  endproperty
  a_trip: assert property (p_trip) else $error("hv not tripped");

endmodule : ftao_alarm_outputs

// ==== ftao_plc_model.sv ====
// partner model: serial master that keeps the remote enable alive
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// poll generator
// ----------------------------------------------------------------------------
// a slow master is modelled by a larger gap; the gap stays far below the
// keep-alive limit so that high voltage must never drop for lack of polls
module ftao_plc_model #(
  parameter int POLL_GAP = 100
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable,
  output logic remote_enable_poll
);
  int gap_cnt;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_cnt <= 0;
      remote_enable_poll <= 1'b0;
    end else begin
      remote_enable_poll <= 1'b0;
      if (enable && gap_cnt >= POLL_GAP - 1) begin
        gap_cnt <= 0;
        remote_enable_poll <= 1'b1;
      end else begin
        gap_cnt <= gap_cnt + 1;
      end
    end
  end
endmodule : ftao_plc_model

// ==== ftao_alarm_outputs_tb_top.sv ====
// testbench: directed scenarios for the fault type alarm outputs block
`timescale 1ns/1ps

module ftao_alarm_outputs_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic discharge_pin = 1'b0;
  logic contact_pin = 1'b0;
  logic fault_reset_pin = 1'b0;
  logic panel_reset = 1'b0;
  logic count_reset = 1'b0;
  logic [15:0] run_cycles_per_tick = 16'h0014;
  logic serial_mode = 1'b1;
  logic remote_enable_poll;
  logic [1:0] total_fault_alarm_mode = 2'h0;
  logic any_barewire_alarm_mode = 1'b0;
  logic any_pinhole_alarm_mode = 1'b0;
  logic gross_barewire_alarm_mode = 1'b0;
  logic [8:0] alarm_time = 9'h001;
  logic combination_select = 1'b0;
  logic [15:0] pin_thr = 16'h0002;
  logic total_fault_alarm, any_barewire_alarm, any_pinhole_alarm, gross_barewire_alarm;
  logic total_fault_limit_out, pinhole_limit_out, contact_limit_out;
  logic multi_pinhole_limit_out, gross_barewire_limit_out, combination_limit_out, hv_enable;
  ftao_pkg::ftao_faults_t fault_event;
  logic [10:0] outs;
  logic [3:0] seen_ev = 4'h0;
  logic clr_ev = 1'b0;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;

  always #10 clk_sys = ~clk_sys;

  // outputs packed for one compare: alarms, limits, then hv
  assign outs = {total_fault_alarm, any_barewire_alarm, any_pinhole_alarm,
    gross_barewire_alarm, total_fault_limit_out, pinhole_limit_out, contact_limit_out,
    multi_pinhole_limit_out, gross_barewire_limit_out, combination_limit_out, hv_enable};

  // events are one-cycle pulses, so they are gathered here between clears
  always @(posedge clk_sys) begin
    seen_ev <= clr_ev ? 4'h0 : (seen_ev | fault_event);
  end

  ftao_alarm_outputs i_dut (.clk_sys(clk_sys), .rst(rst), .discharge_pin(discharge_pin),
    .contact_pin(contact_pin), .fault_reset_pin(fault_reset_pin), .panel_reset(panel_reset),
    .count_reset(count_reset), .run_cycles_per_tick(run_cycles_per_tick),
    .serial_mode(serial_mode), .remote_enable_poll(remote_enable_poll),
    .total_fault_alarm_mode(total_fault_alarm_mode), .total_fault_alarm_time(alarm_time),
    .any_barewire_alarm_mode(any_barewire_alarm_mode),
    .any_barewire_alarm_time(alarm_time), .any_pinhole_alarm_mode(any_pinhole_alarm_mode),
    .any_pinhole_alarm_time(alarm_time),
    .gross_barewire_alarm_mode(gross_barewire_alarm_mode),
    .gross_barewire_alarm_time(alarm_time), .total_fault_threshold(16'h0003),
    .pinhole_threshold(pin_thr), .contact_threshold(16'h0001),
    .multi_pinhole_threshold(16'h0001), .gross_barewire_threshold(16'h0001),
    .combination_select(combination_select), .total_fault_alarm(total_fault_alarm),
    .any_barewire_alarm(any_barewire_alarm), .any_pinhole_alarm(any_pinhole_alarm),
    .gross_barewire_alarm(gross_barewire_alarm), .total_fault_limit_out(total_fault_limit_out),
    .pinhole_limit_out(pinhole_limit_out), .contact_limit_out(contact_limit_out),
    .multi_pinhole_limit_out(multi_pinhole_limit_out),
    .gross_barewire_limit_out(gross_barewire_limit_out),
    .combination_limit_out(combination_limit_out), .hv_enable(hv_enable),
    .fault_event(fault_event));

  ftao_plc_model #(.POLL_GAP(100)) i_plc (.clk_sys(clk_sys), .rst(rst), .enable(serial_mode),
    .remote_enable_poll(remote_enable_poll));

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // discharge for len cycles, with contact if asked; ends settled past the sync delay
  task automatic arc(input logic with_contact, input int len);
    @(posedge clk_sys);
    clr_ev <= 1'b1;
    @(posedge clk_sys);
    clr_ev <= 1'b0;
    discharge_pin <= 1'b1;
    contact_pin <= with_contact;
    repeat (len) @(posedge clk_sys);
    discharge_pin <= 1'b0;
    contact_pin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
  endtask : arc

  task automatic strobe(input logic panel);
    @(posedge clk_sys);
    panel_reset <= panel;
    count_reset <= ~panel;
    @(posedge clk_sys);
    panel_reset <= 1'b0;
    count_reset <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask : strobe

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic test_pinhole();
    arc(1'b0, 5);
    check({12'h000, seen_ev}, 16'h0008);
    check({5'h00, outs}, 16'h0501);
    arc(1'b0, 5);
    check({5'h00, outs}, 16'h0523);
    strobe(1'b0);
    check({5'h00, outs}, 16'h0501);
    $display("test_pinhole done");
  endtask : test_pinhole

  task automatic test_multi();
    arc(1'b0, 30);
    check({12'h000, seen_ev}, 16'h000A);
    check({5'h00, outs}, 16'h050B);
    strobe(1'b0);
    $display("test_multi done");
  endtask : test_multi

  task automatic test_barewire();
    any_barewire_alarm_mode <= 1'b1;
    gross_barewire_alarm_mode <= 1'b1;
    combination_select <= 1'b1;
    arc(1'b1, 5);
    check({12'h000, seen_ev}, 16'h0004);
    check({5'h00, outs}, 16'h0713);
    arc(1'b1, 30);
    check({12'h000, seen_ev}, 16'h0005);
    check({5'h00, outs}, 16'h07D7);
    // a closure far shorter than the debounce must leave held alarms alone
    fault_reset_pin <= 1'b1;
    repeat (10) @(posedge clk_sys);
    fault_reset_pin <= 1'b0;
    repeat (200) @(posedge clk_sys);
    #1;
    check({5'h00, outs & 11'h280}, 16'h0280);
    strobe(1'b1);
    check({5'h00, outs & 11'h280}, 16'h0000);
    $display("test_barewire done");
  endtask : test_barewire

  task automatic test_hv_trip();
    total_fault_alarm_mode <= 2'h2;
    arc(1'b0, 5);
    check({5'h00, outs & 11'h401}, 16'h0400);
    repeat (100) @(posedge clk_sys);
    #1;
    check({5'h00, outs & 11'h401}, 16'h0400);
    strobe(1'b1);
    check({5'h00, outs & 11'h001}, 16'h0001);
    $display("test_hv_trip done");
  endtask : test_hv_trip

  // held pinhole alarm, then the threshold moved while the count stands
  task automatic test_held_pin();
    any_pinhole_alarm_mode <= 1'b1;
    total_fault_alarm_mode <= 2'h1;
    strobe(1'b1);
    check({5'h00, outs & 11'h501}, 16'h0001);
    arc(1'b0, 5);
    check({5'h00, outs & 11'h521}, 16'h0521);
    pin_thr <= 16'h0003;
    repeat (3) @(posedge clk_sys);
    #1;
    check({5'h00, outs & 11'h020}, 16'h0000);
    pin_thr <= 16'h0002;
    repeat (3) @(posedge clk_sys);
    #1;
    check({5'h00, outs & 11'h020}, 16'h0020);
    $display("test_held_pin done");
  endtask : test_held_pin

  // --------------------------------------------------------------------------
  // main sequence and hang guard
  // --------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check({5'h00, outs}, 16'h0001);
    $display("reset check done");
    test_pinhole();
    test_multi();
    test_barewire();
    test_hv_trip();
    test_held_pin();
    complete_run();
  end

  // the scenarios need about 530 cycles; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
endmodule : ftao_alarm_outputs_tb_top
